// ===== hw/nv_sram_host.sv
// Host controller driving an nvSRAM through its asynchronous pins
// Functional notes
// [RULE1] Read: select, output enable low, others high
// [RULE2] Read data follows address while held
// [RULE3] Write: select, write low; address stable
// [RULE4] Output enable stays high during writes
// [RULE5] Device blocks access during transfers
// [RULE6] Device saves on supply loss
// [RULE7] Auto and pin saves need prior write
// [RULE8] Low store pin requests save after delay
// [RULE9] Device pulls store pin low while busy
// [RULE10] New writes wait for store pin high
// [RULE11] Device restores at power-up
// [RULE12] Save sequence: six reads ending 0x8FC0
// [RULE13] Sequence must run uninterrupted
// [RULE14] Sequence uses read cycles only
// [RULE15] Wait the save duration before access
// [RULE16] Save erases then programs all cells
// [RULE17] Restore sequence ends with 0x4C63
// [RULE18] Wait the restore duration before access
// [RULE19] Device refuses writes at low supply
// [RULE20] Write needs fresh select or write edge
// [RULE21] Only low sixteen bits form sequence
// [RULE22] Auto-save off 0x8B45, on 0x4B46
// [RULE23] Device matches sequence in six states
// [RULE24] Device tracks dirty flag for saves
`default_nettype none
module nv_sram_host #(
  parameter int SAVE_NS    = 15000000,  // Save duration
  parameter int RESTORE_NS = 20000,     // Restore duration
  parameter int PWRUP_NS   = 20000000   // powerup_restore_duration
) (
  input  wire logic                                   clock_i,      // Clock
  input  wire logic                                   rst_n_i,      // Sync reset, active low
  input  wire logic                                   req_valid_i,  // Command request
  output logic                                        req_ready_o,  // Command taken
  input  wire nv_sram_host_pkg::cmd_t                 req_cmd_i,    // Command
  input  wire logic [nv_sram_host_pkg::ADDR_W-1:0]    req_addr_i,   // Byte address
  input  wire logic [nv_sram_host_pkg::DATA_W-1:0]    req_wdata_i,  // Write data
  output logic                                        rsp_valid_o,  // Command done pulse
  output logic      [nv_sram_host_pkg::DATA_W-1:0]    rsp_rdata_o,  // Read data
  output logic                                        busy_o,       // Device busy seen
  output logic      [nv_sram_host_pkg::ADDR_W-1:0]    addr_o,       // Address pins
  output logic                                        chip_sel_n_o, // Chip select, low
  output logic                                        out_en_n_o,   // Output enable, low
  output logic                                        wr_en_n_o,    // Write enable, low
  input  wire logic [nv_sram_host_pkg::DATA_W-1:0]    data_io_i,    // Data pins in
  output logic      [nv_sram_host_pkg::DATA_W-1:0]    data_io_o,    // Data pins out
  output logic                                        data_io_oe_o, // Data drive enable
  input  wire logic                                   store_req_busy_n_i,  // Pin level in
  output logic                                        store_req_busy_n_o,  // Pin drive value
  output logic                                        store_req_busy_n_oe_o // Pin drive enable
);
  // Duration in ns to cycles, rounded up; wide product so long waits do not overflow
  function automatic int ns_to_cyc(input longint ns);
    ns_to_cyc = int'((ns * 1000 + nv_sram_host_pkg::CLK_PS - 1) / nv_sram_host_pkg::CLK_PS);
  endfunction : ns_to_cyc

  localparam int SAVE_CYC    = ns_to_cyc(SAVE_NS);
  localparam int RESTORE_CYC = ns_to_cyc(RESTORE_NS);
  localparam int PWRUP_CYC   = ns_to_cyc(PWRUP_NS);

  typedef enum logic [3:0] {
    ST_PWRUP, ST_IDLE, ST_SETUP, ST_RD, ST_WR, ST_RECOVER, ST_SEQ_SETUP, ST_SEQ_RD,
    ST_SEQ_GAP, ST_PIN_REQ, ST_WAIT
  } state_t;

  // ----------------------------------------------------------------
  // Pin input synchronisation
  // ----------------------------------------------------------------
  logic [nv_sram_host_pkg::DATA_W:0] pins_sync;
  nv_sram_pin_sync #(
    .W (nv_sram_host_pkg::DATA_W + 1)
  ) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .pin_i   ({store_req_busy_n_i, data_io_i}),
    .sync_o  (pins_sync)
  );
  logic store_pin_sync;
  assign store_pin_sync = pins_sync[nv_sram_host_pkg::DATA_W];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  state_t                              state_ff;
  logic [nv_sram_host_pkg::CNT_W-1:0]  cnt_ff;
  logic [2:0]                          seq_idx_ff;
  logic [15:0]                         seq_last_ff;
  logic [nv_sram_host_pkg::CNT_W-1:0]  wait_cyc_ff;
  nv_sram_host_pkg::cmd_t              cmd_ff;
  logic [nv_sram_host_pkg::DATA_W-1:0] wdata_ff;
  logic                                cnt_done;
  logic                                take;

  assign cnt_done    = (cnt_ff == '0);
  assign take        = (state_ff == ST_IDLE) && req_valid_i && store_pin_sync;
  assign req_ready_o = (state_ff == ST_IDLE) && store_pin_sync; // [RULE10]
  assign busy_o      = !store_pin_sync || (state_ff == ST_WAIT) || (state_ff == ST_PWRUP); // [RULE9]

  function automatic logic [nv_sram_host_pkg::CNT_W-1:0] cyc(input int n);
    cyc = nv_sram_host_pkg::CNT_W'(n - 1);
  endfunction : cyc

  function automatic logic [15:0] last_addr(input nv_sram_host_pkg::cmd_t c);
    case (c)
      nv_sram_host_pkg::CMD_SAVE:     last_addr = nv_sram_host_pkg::SEQ_SAVE;     // [RULE12]
      nv_sram_host_pkg::CMD_RESTORE:  last_addr = nv_sram_host_pkg::SEQ_RESTORE;  // [RULE17]
      nv_sram_host_pkg::CMD_AUTO_OFF: last_addr = nv_sram_host_pkg::SEQ_AUTO_OFF; // [RULE22]
      default:                        last_addr = nv_sram_host_pkg::SEQ_AUTO_ON;  // [RULE22]
    endcase
  endfunction : last_addr

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_ff    <= ST_PWRUP;
      cnt_ff      <= '0;
      seq_idx_ff  <= '0;
      seq_last_ff <= '0;
      wait_cyc_ff <= '0;
      cmd_ff      <= nv_sram_host_pkg::CMD_READ;
      wdata_ff    <= '0;
    end
    else
    begin
      case (state_ff)
        ST_PWRUP:
        begin
          state_ff <= ST_WAIT; // [RULE11]
          cnt_ff   <= cyc(PWRUP_CYC);
        end
        ST_IDLE:
        begin
          if (take)
          begin
            cmd_ff   <= req_cmd_i;
            wdata_ff <= req_wdata_i;
            cnt_ff   <= (req_cmd_i == nv_sram_host_pkg::CMD_PIN_SAVE) ?
                        cyc(nv_sram_host_pkg::SDELAY_CYC) : // [RULE8]
                        cyc(nv_sram_host_pkg::SETUP_CYC);
            seq_idx_ff  <= '0;
            seq_last_ff <= last_addr(req_cmd_i);
            case (req_cmd_i)
              nv_sram_host_pkg::CMD_READ:     state_ff <= ST_SETUP;
              nv_sram_host_pkg::CMD_WRITE:    state_ff <= ST_SETUP;
              nv_sram_host_pkg::CMD_PIN_SAVE: state_ff <= ST_PIN_REQ; // [RULE8]
              default:                        state_ff <= ST_SEQ_SETUP; // [RULE13]
            endcase
            wait_cyc_ff <= (req_cmd_i == nv_sram_host_pkg::CMD_RESTORE) ?
                           cyc(RESTORE_CYC) : cyc(SAVE_CYC);
          end
        end
        ST_SETUP:
          if (cnt_done)
          begin
            state_ff <= (cmd_ff == nv_sram_host_pkg::CMD_WRITE) ? ST_WR : ST_RD;
            cnt_ff   <= (cmd_ff == nv_sram_host_pkg::CMD_WRITE) ?
                        cyc(nv_sram_host_pkg::WPULSE_CYC) : cyc(nv_sram_host_pkg::ACCESS_CYC + 2);
          end
          else
            cnt_ff <= cnt_ff - 1'b1;
        ST_RD, ST_WR, ST_SEQ_RD:
          if (cnt_done)
          begin
            cnt_ff <= cyc(nv_sram_host_pkg::RECOVER_CYC);
            if (state_ff != ST_SEQ_RD)
              state_ff <= ST_RECOVER;
            else if (seq_idx_ff == 3'h5)
            begin
              state_ff <= ST_WAIT; // [RULE15] [RULE18]
              cnt_ff   <= wait_cyc_ff;
            end
            else
            begin
              state_ff   <= ST_SEQ_GAP;
              seq_idx_ff <= seq_idx_ff + 1'b1;
            end
          end
          else
            cnt_ff <= cnt_ff - 1'b1;
        ST_SEQ_SETUP, ST_SEQ_GAP:
          if (cnt_done)
          begin
            state_ff <= ST_SEQ_RD;
            cnt_ff   <= cyc(nv_sram_host_pkg::ACCESS_CYC);
          end
          else
            cnt_ff <= cnt_ff - 1'b1;
        ST_PIN_REQ:
          if (cnt_done)
          begin
            state_ff <= ST_WAIT; // [RULE7]
            cnt_ff   <= wait_cyc_ff;
          end
          else
            cnt_ff <= cnt_ff - 1'b1;
        ST_RECOVER, ST_WAIT:
          if (cnt_done && store_pin_sync)
            state_ff <= ST_IDLE; // [RULE5]
          else if (!cnt_done)
            cnt_ff <= cnt_ff - 1'b1;
        default:
          state_ff <= ST_IDLE;
      endcase
      if (state_ff == ST_PIN_REQ && cnt_ff == '0)
        cnt_ff <= wait_cyc_ff;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic rd_phase;
  logic wr_phase;
  logic seq_phase;
  assign rd_phase  = (state_ff == ST_RD);
  assign wr_phase  = (state_ff == ST_WR);
  assign seq_phase = (state_ff == ST_SEQ_RD) || (state_ff == ST_SEQ_SETUP) ||
                     (state_ff == ST_SEQ_GAP);

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      addr_o       <= '0;
      chip_sel_n_o <= 1'b1;
      out_en_n_o   <= 1'b1;
      wr_en_n_o    <= 1'b1;
      data_io_o    <= '0;
      data_io_oe_o <= 1'b0;
    end
    else
    begin
      if (take)
        addr_o <= req_addr_i; // [RULE3]
      else if (seq_phase)
        addr_o <= {1'b0, nv_sram_host_pkg::seq_addr(seq_idx_ff, seq_last_ff)}; // [RULE21]
      chip_sel_n_o <= !((state_ff == ST_SETUP && cnt_done) || ((rd_phase || wr_phase) &&
                        !cnt_done) || (state_ff == ST_SEQ_SETUP && cnt_done) ||
                        (state_ff == ST_SEQ_GAP && cnt_done) ||
                        (state_ff == ST_SEQ_RD && !cnt_done)); // [RULE14] [RULE20]
      out_en_n_o   <= !((state_ff == ST_SETUP && cnt_done && cmd_ff != nv_sram_host_pkg::CMD_WRITE)
                        || (rd_phase && !cnt_done)); // [RULE1] [RULE4]
      wr_en_n_o    <= !((state_ff == ST_SETUP && cnt_done && cmd_ff == nv_sram_host_pkg::CMD_WRITE)
                        || (wr_phase && !cnt_done)); // [RULE3]
      data_io_o    <= wdata_ff;
      data_io_oe_o <= (cmd_ff == nv_sram_host_pkg::CMD_WRITE) &&
                      ((state_ff == ST_SETUP && cnt_done) || wr_phase); // [RULE4]
    end
  end

  // Store-request pin: open drain, driven low only during a pin save request
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      store_req_busy_n_oe_o <= 1'b0;
    else
      store_req_busy_n_oe_o <= (state_ff == ST_IDLE && take &&
                                req_cmd_i == nv_sram_host_pkg::CMD_PIN_SAVE) ||
                               (state_ff == ST_PIN_REQ && !cnt_done); // [RULE8]
  end
  assign store_req_busy_n_o = 1'b0;

  // ----------------------------------------------------------------
  // Response
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
    end
    else
    begin
      // Power-up wait keeps cmd_ff at read, so it answers nothing
      rsp_valid_o <= ((rd_phase || wr_phase) && cnt_done) ||
                     (state_ff == ST_WAIT && cnt_done && store_pin_sync &&
                      cmd_ff != nv_sram_host_pkg::CMD_READ &&
                      cmd_ff != nv_sram_host_pkg::CMD_WRITE);
      if (rd_phase && cnt_done)
        rsp_rdata_o <= pins_sync[nv_sram_host_pkg::DATA_W-1:0]; // [RULE2]
    end
  end
endmodule : nv_sram_host
`default_nettype wire

// ===== hw/nv_sram_host_pkg.sv
// Package: pin timing, sequence addresses and commands of the nvSRAM host controller
`default_nettype none
package nv_sram_host_pkg;
  localparam int ADDR_W     = 17;
  localparam int DATA_W     = 8;
  localparam int SEQ_ADDR_W = 16;
  localparam int CLK_PS     = 4000;
  // Pin timing figures in ns
  localparam int ACCESS_NS       = 45;
  localparam int WRITE_PULSE_NS  = 35;
  localparam int SETUP_NS        = 5;
  localparam int RECOVER_NS      = 10;
  localparam int STORE_DELAY_NS  = 25;
  // Cycle counts, least times rounded up
  localparam int ACCESS_CYC   = (ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WPULSE_CYC   = (WRITE_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SETUP_CYC    = (SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RECOVER_CYC  = (RECOVER_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SDELAY_CYC   = (STORE_DELAY_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W        = 24;
  // Software mode address list
  localparam logic [15:0] SEQ_A0        = 16'h4E38;
  localparam logic [15:0] SEQ_A1        = 16'hB1C7;
  localparam logic [15:0] SEQ_A2        = 16'h83E0;
  localparam logic [15:0] SEQ_A3        = 16'h7C1F;
  localparam logic [15:0] SEQ_A4        = 16'h703F;
  localparam logic [15:0] SEQ_SAVE      = 16'h8FC0;
  localparam logic [15:0] SEQ_RESTORE   = 16'h4C63;
  localparam logic [15:0] SEQ_AUTO_OFF  = 16'h8B45;
  localparam logic [15:0] SEQ_AUTO_ON   = 16'h4B46;
  // Host commands
  typedef enum logic [2:0] {
    CMD_READ, CMD_WRITE, CMD_SAVE, CMD_RESTORE, CMD_AUTO_OFF, CMD_AUTO_ON, CMD_PIN_SAVE
  } cmd_t;
  function automatic logic [15:0] seq_addr(input logic [2:0] idx, input logic [15:0] last);
    case (idx)
      3'h0:    seq_addr = SEQ_A0;
      3'h1:    seq_addr = SEQ_A1;
      3'h2:    seq_addr = SEQ_A2;
      3'h3:    seq_addr = SEQ_A3;
      3'h4:    seq_addr = SEQ_A4;
      default: seq_addr = last;
    endcase
  endfunction : seq_addr
endpackage : nv_sram_host_pkg
`default_nettype wire

// ===== hw/nv_sram_pin_sync.sv
// Two-flop synchroniser for pins entering the clock domain
`default_nettype none
module nv_sram_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i, // Clock
  input  wire logic         rst_n_i, // Sync reset, active low
  input  wire logic [W-1:0] pin_i,   // Asynchronous pins
  output logic      [W-1:0] sync_o   // Synchronised pins
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= '1;
      sync_ff <= '1;
    end
    else
    begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
    end
  end
  assign sync_o = sync_ff;
endmodule : nv_sram_pin_sync
`default_nettype wire

// ===== test/nv_sram_host_sva.sv
// Checker for the pin behaviour of the nvSRAM host controller
`default_nettype none
module nv_sram_host_sva (
  input wire logic        clock_i,               // Clock
  input wire logic        rst_n_i,               // Sync reset, active low
  input wire logic        req_ready_o,           // Command taken
  input wire logic        rsp_valid_o,           // Command done pulse
  input wire logic [16:0] addr_o,                // Address pins
  input wire logic        chip_sel_n_o,          // Chip select
  input wire logic        out_en_n_o,            // Output enable
  input wire logic        wr_en_n_o,             // Write enable
  input wire logic        data_io_oe_o,          // Data drive enable
  input wire logic        store_req_busy_n_i,    // Store pin level
  input wire logic        store_req_busy_n_oe_o  // Store pin pull
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_read_strobes: assert property (!out_en_n_o |-> !chip_sel_n_o && wr_en_n_o)
    else $error("output enable low outside a read");
  a_rsp_one_cycle: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("response longer than one cycle");
  a_write_addr_stable: assert property (
    $past(!chip_sel_n_o && !wr_en_n_o) && !chip_sel_n_o && !wr_en_n_o |-> $stable(addr_o))
    else $error("address moved during write");
  a_select_addr_setup: assert property ($fell(chip_sel_n_o) |-> $stable(addr_o))
    else $error("address changed as select fell");
  a_write_data_driven: assert property (
    (!chip_sel_n_o && !wr_en_n_o) [*2] |-> data_io_oe_o)
    else $error("write without data drive");
  a_write_oe_high: assert property (!wr_en_n_o |-> out_en_n_o)
    else $error("output enable low during write");
  a_read_no_drive: assert property (!out_en_n_o |-> !data_io_oe_o)
    else $error("bus contention during read");
  a_pin_req_hold: assert property ($rose(store_req_busy_n_oe_o) |-> store_req_busy_n_oe_o [*7])
    else $error("store request shorter than delay");
  a_busy_refused: assert property ((!store_req_busy_n_i) [*4] |-> !req_ready_o)
    else $error("command taken while store pin low");
  a_write_busy_block: assert property ((!store_req_busy_n_i) [*6] |-> !$fell(wr_en_n_o))
    else $error("write started while store pin low");
  // ----------------------------------------
  // Covers
  // ----------------------------------------
  c_pin_save: cover property ($rose(store_req_busy_n_oe_o));
  c_write: cover property ($rose(wr_en_n_o));
  c_seq_save: cover property ($fell(chip_sel_n_o) && addr_o[15:0] == 16'h8FC0);
  c_rsp: cover property (rsp_valid_o);
endmodule : nv_sram_host_sva
bind nv_sram_host nv_sram_host_sva nv_sram_host_sva_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .addr_o(addr_o),
  .chip_sel_n_o(chip_sel_n_o), .out_en_n_o(out_en_n_o), .wr_en_n_o(wr_en_n_o),
  .data_io_oe_o(data_io_oe_o), .store_req_busy_n_i(store_req_busy_n_i),
  .store_req_busy_n_oe_o(store_req_busy_n_oe_o));
`default_nettype wire

// ===== test/nv_sram_dev_model.sv
// Behavioural model of the nvSRAM device on the asynchronous pins
`default_nettype none
module nv_sram_dev_model #(
  parameter int SAVE_NS    = 400,
  parameter int RESTORE_NS = 400
) (
  input  wire logic [16:0] addr_i,    // Address pins
  input  wire logic        cs_n_i,    // Chip select
  input  wire logic        oe_n_i,    // Output enable
  input  wire logic        we_n_i,    // Write enable
  input  wire logic [7:0]  dq_i,      // Data bus level
  input  wire logic        busy_n_i,  // Store pin level
  output logic      [7:0]  dq_o,      // Data driven or stale inverse
  output logic             busy_oe_o  // Pulls store pin low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [int];
  logic [7:0]  nv [int];
  logic [15:0] seq [5] = '{16'h4E38, 16'hB1C7, 16'h83E0, 16'h7C1F, 16'h703F};
  logic [7:0]  last = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic        dirty = 1'b0;
  logic        blocked = 1'b0;
  logic        auto_on = 1'b1;
  int          idx = 0;
  logic        wr_act = 1'b0;
  logic        rd_act = 1'b0;
  logic        step = 1'b0;
  initial busy_oe_o = 1'b0;
  initial mem = nv;
  // ----------------------------------------
  // Read path and write capture
  // ----------------------------------------
  always @* begin
    if (!cs_n_i && !oe_n_i && we_n_i && busy_n_i && !blocked)
    begin
      dq_o = mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 8'h00;
      last = dq_o;
    end
    else dq_o = ~last;
    if (!cs_n_i && !we_n_i)
    begin
      wd = dq_i;
      wr_act = 1'b1;
      rd_act = 1'b0;
    end
    else if (!cs_n_i && !wr_act) rd_act = 1'b1;
  end
  task automatic commit();
    if (!blocked && busy_n_i)
    begin
      mem[int'(addr_i)] = wd;
      dirty = 1'b1;
    end
    idx = 0;
  endtask : commit
  task automatic do_save();
    blocked = 1'b1;
    busy_oe_o = 1'b1;
    #(SAVE_NS);
    nv = mem;
    dirty = 1'b0;
    busy_oe_o = 1'b0;
    blocked = 1'b0;
  endtask : do_save
  // Write ends on whichever strobe rises first, even in one time step
  always @(posedge we_n_i or posedge cs_n_i) if (wr_act)
  begin
    wr_act = 1'b0;
    commit();
  end
  // ----------------------------------------
  // Sequence matcher on select-ended reads
  // ----------------------------------------
  always @(posedge cs_n_i) begin
    step = rd_act && !blocked; // Writes never step the matcher
    rd_act = 1'b0;
    if (step && idx < 5) idx = (addr_i[15:0] == seq[idx]) ? idx + 1 :
      ((addr_i[15:0] == seq[0]) ? 1 : 0);
    else if (step)
    begin
      idx = 0;
      case (addr_i[15:0])
        16'h8FC0: do_save();
        16'h4C63: begin blocked = 1'b1; #(RESTORE_NS); mem = nv; dirty = 1'b0; blocked = 1'b0; end
        16'h8B45: auto_on = 1'b0;
        16'h4B46: auto_on = 1'b1;
        default: idx = 0;
      endcase
    end
  end
  always @(negedge busy_n_i) if (!busy_oe_o)
  begin
    #25;
    if (dirty) do_save();
  end
endmodule : nv_sram_dev_model
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking testbench of the nvSRAM host controller
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  nv_sram_host_pkg::cmd_t req_cmd_i = nv_sram_host_pkg::CMD_READ;
  logic [16:0] req_addr_i = 17'h00000;
  logic [7:0]  req_wdata_i = 8'h00;
  logic req_ready_o, rsp_valid_o, busy_o, chip_sel_n_o, out_en_n_o, wr_en_n_o;
  logic data_io_oe_o, store_req_busy_n_o, store_req_busy_n_oe_o, dev_busy_oe, store_req_busy_n;
  logic [7:0] rsp_rdata_o, data_io_o, dev_dq, dq_bus, d [6];
  logic [16:0] addr_o, a [6];
  logic [8:0] exp_q [$];
  logic [8:0] e;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int seed = 32'h3473611E;
  assign dq_bus = data_io_oe_o ? data_io_o : dev_dq;
  assign store_req_busy_n = !((store_req_busy_n_oe_o && !store_req_busy_n_o) || dev_busy_oe);
  always #2 clock_i = ~clock_i;
  nv_sram_host #(.SAVE_NS(400), .RESTORE_NS(400), .PWRUP_NS(400)) nv_sram_host_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .busy_o(busy_o), .addr_o(addr_o),
    .chip_sel_n_o(chip_sel_n_o), .out_en_n_o(out_en_n_o), .wr_en_n_o(wr_en_n_o),
    .data_io_i(dq_bus), .data_io_o(data_io_o), .data_io_oe_o(data_io_oe_o),
    .store_req_busy_n_i(store_req_busy_n), .store_req_busy_n_o(store_req_busy_n_o),
    .store_req_busy_n_oe_o(store_req_busy_n_oe_o));
  nv_sram_dev_model #(.SAVE_NS(400), .RESTORE_NS(400)) nv_sram_dev_model_inst (
    .addr_i(addr_o), .cs_n_i(chip_sel_n_o), .oe_n_i(out_en_n_o), .we_n_i(wr_en_n_o),
    .dq_i(dq_bus), .busy_n_i(store_req_busy_n), .dq_o(dev_dq), .busy_oe_o(dev_busy_oe));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic issue(input nv_sram_host_pkg::cmd_t c, input logic [16:0] ad,
                       input logic [7:0] wd, input logic [8:0] ex);
    exp_q.push_back(ex);
    while (req_ready_o !== 1'b1) @(posedge clock_i) #1;
    req_valid_i = 1'b1;
    req_cmd_i = c;
    req_addr_i = ad;
    req_wdata_i = wd;
    @(posedge clock_i) #1;
    req_valid_i = 1'b0;
  endtask : issue
  task automatic wr(input logic [16:0] ad, input logic [7:0] wd);
    issue(nv_sram_host_pkg::CMD_WRITE, ad, wd, 9'h000);
  endtask : wr
  task automatic rd(input logic [16:0] ad, input logic [7:0] ex);
    issue(nv_sram_host_pkg::CMD_READ, ad, 8'h00, {1'b1, ex});
  endtask : rd
  // ----------------------------------------
  // Response monitor and timeout
  // ----------------------------------------
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fail_count++;
      summarize();
    end
    if (rsp_valid_o === 1'b1)
    begin
      if (exp_q.size() == 0) check("unexpected response", 8'h00, 8'hFF);
      else
      begin
        e = exp_q.pop_front();
        if (e[8]) check("read data", rsp_rdata_o, e[7:0]);
      end
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    @(posedge clock_i) #1;
    check("busy after reset", 8'(busy_o), 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      a[i] = {1'b0, 4'(i + 1), 12'($random(seed))};
      d[i] = 8'($random(seed));
      wr(a[i], d[i]);
    end
    wr(17'h10123, 8'hA5);
    wr(17'h00123, 8'h5A);
    rd(17'h10123, 8'hA5);
    for (int i = 0; i < 6; i++) rd(a[i], d[i]);
    issue(nv_sram_host_pkg::CMD_SAVE, 17'h00000, 8'h00, 9'h000);
    wr(a[0], ~d[0]);
    rd(a[0], ~d[0]);
    issue(nv_sram_host_pkg::CMD_RESTORE, 17'h00000, 8'h00, 9'h000);
    rd(a[0], d[0]);
    wr(a[1], ~d[1]);
    issue(nv_sram_host_pkg::CMD_PIN_SAVE, 17'h00000, 8'h00, 9'h000);
    wr(a[1], d[1]);
    issue(nv_sram_host_pkg::CMD_RESTORE, 17'h00000, 8'h00, 9'h000);
    rd(a[1], ~d[1]);
    issue(nv_sram_host_pkg::CMD_AUTO_OFF, 17'h00000, 8'h00, 9'h000);
    issue(nv_sram_host_pkg::CMD_AUTO_ON, 17'h00000, 8'h00, 9'h000);
    rd(17'h00123, 8'h5A);
    while (exp_q.size() != 0) @(posedge clock_i);
    repeat (4) @(posedge clock_i);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
